//--- hdl/fbs_pkg.sv
// Constants and types for the flash boot selection block
package fbs_pkg;
  localparam int USER_FLASH_BYTES = 32768;
  localparam int BOOT_FLASH_BYTES = 2048;
  localparam int PAGE_SHIFT = 7;
  localparam int EXTRA_FLASH_ROW_BITS = 7;
  localparam logic [15:0] USER_START_PC = 16'h0000;
  localparam logic [15:0] BOOT_START_PC = 16'hF800;
  localparam logic [15:0] USER_TOP = 16'h7FFF;
  localparam logic [7:0] FLASH_CONTROL_REG_HW_BOOT = 8'h00;
  localparam logic [7:0] FLASH_CONTROL_REG_SW_BOOT = 8'hF0;
  localparam logic [7:0] OFS_FLASH_CONTROL_REG = 8'h00;
  localparam logic [7:0] OFS_AUX = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_SVC = 8'h0C;
  localparam int FMOD_LO_BIT = 1;
  localparam int FMOD_HI_BIT = 2;
  localparam int AUX_MAP_BIT = 5;
  localparam int STAT_HW_BIT = 16;
  localparam int STAT_JUMP_BIT = 17;
  localparam int STAT_PAGE_LSB = 24;
  localparam int SVC_SEL_LSB = 8;
  localparam int SVC_WE_BIT = 10;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {EXEC_USER, EXEC_BOOT, EXEC_EXT} fbs_exec_t;
  typedef enum logic [2:0] {SPC_USER, SPC_BOOT, SPC_EEPROM, SPC_HWBYTE, SPC_EXTRA_FLASH_ROW} fbs_space_t;
  typedef enum logic [1:0] {FMOD_MAIN, FMOD_EXTRA_FLASH_ROW, FMOD_HWBYTE, FMOD_ALT} fbs_fmod_t;
  typedef enum logic [1:0] {SVC_JUMP, SVC_VECTOR, SVC_EXTRA, SVC_STATUS} fbs_svc_t;

  typedef struct packed {
    logic       req;
    logic [15:0] addr;
  } fbs_code_req_t;

  typedef struct packed {
    logic       req;
    logic       wr;
    fbs_space_t space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fbs_mem_req_t;

  typedef struct packed {
    logic       req;
    logic       serial;
    logic       boot;
    logic [15:0] addr;
    logic [7:0] data;
  } fbs_prg_req_t;

  typedef struct packed {
    logic       ack;
    logic       denied;
    logic [7:0] data;
  } fbs_ans_t;

  typedef struct packed {
    logic       jump;
    logic [7:0] vector;
    logic [7:0] extra;
    logic [7:0] status;
    logic [7:0] hw_byte;
  } fbs_nv_t;

  // Factory contents; extra, status and hardware byte values are plain defaults
  localparam fbs_nv_t NV_DELIVERED = '{jump: 1'b0, vector: 8'hFC, extra: 8'hFF,
                                       status: 8'hFF, hw_byte: 8'hFF};

  typedef struct packed {
    logic        in_reset;
    logic        hw_boot;
    logic        jump_snap;
    logic [7:0]  flash_control_reg;
    logic        map_en;
    logic [15:0] start_pc;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    fbs_svc_t    svc_sel;
    logic [7:0]  last_page;
    fbs_ans_t    code_ans;
    fbs_ans_t    mem_ans;
    fbs_ans_t    prg_ans;
  } fbs_state_t;
endpackage

//--- hdl/fbs_flash_boot_select.sv
// Flash maps, access control and reset boot selection with an AHB-Lite slave
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module fbs_flash_boot_select #(
  parameter int USER_BYTES = fbs_pkg::USER_FLASH_BYTES,
  parameter int BOOT_BYTES = fbs_pkg::BOOT_FLASH_BYTES
) (
  input  wire logic                  CLK,
  input  wire logic                  RESETN,
  input  wire logic                  HSEL,
  input  wire logic [31:0]           HADDR,
  input  wire logic [1:0]            HTRANS,
  input  wire logic                  HWRITE,
  input  wire logic [2:0]            HSIZE,
  input  wire logic [31:0]           HWDATA,
  input  wire logic                  HREADY,
  output logic                       HREADYOUT,
  output logic                       HRESP,
  output logic [31:0]                HRDATA,
  input  wire logic                  PROGRAM_STROBE_N,
  input  wire logic                  EXTERNAL_ACCESS_N,
  input  wire logic                  ADDR_LATCH_STROBE,
  input  wire fbs_pkg::fbs_exec_t    EXEC_SRC,
  input  wire fbs_pkg::fbs_code_req_t CODE_REQ,
  output fbs_pkg::fbs_ans_t          CODE_ANS,
  input  wire fbs_pkg::fbs_mem_req_t MEM_REQ,
  output fbs_pkg::fbs_ans_t          MEM_ANS,
  input  wire fbs_pkg::fbs_prg_req_t PRG_REQ,
  output fbs_pkg::fbs_ans_t          PRG_ANS,
  output logic [15:0]                START_PC,
  output logic                       BOOT_MAP_ENABLE,
  output logic                       HW_BOOT
);
  localparam int UA = $clog2(USER_BYTES);
  localparam int BA = $clog2(BOOT_BYTES);

  logic [7:0] user_mem [USER_BYTES];
  logic [7:0] boot_mem [BOOT_BYTES];
  logic [7:0] extra_flash_row_mem [2**fbs_pkg::EXTRA_FLASH_ROW_BITS];

  fbs_pkg::fbs_state_t st;
  fbs_pkg::fbs_state_t next_st;
  fbs_pkg::fbs_nv_t    nv = fbs_pkg::NV_DELIVERED;
  fbs_pkg::fbs_nv_t    next_nv;

  logic                arr_we;
  fbs_pkg::fbs_space_t arr_space;
  logic [15:0]         arr_addr;
  logic [7:0]          arr_data;
  logic [31:0]         reg_rd;
  logic [7:0]          svc_data;
  logic [7:0]          extra_flash_row_peek;
  fbs_pkg::fbs_fmod_t  fmod;

  assign fmod = fbs_pkg::fbs_fmod_t'(st.flash_control_reg[fbs_pkg::FMOD_HI_BIT:fbs_pkg::FMOD_LO_BIT]);
  assign extra_flash_row_peek = extra_flash_row_mem[CODE_REQ.addr[fbs_pkg::EXTRA_FLASH_ROW_BITS-1:0]];

  // Access rights by where code runs; writes never stall reads
  function automatic logic access_ok(fbs_pkg::fbs_exec_t ex,
                                     fbs_pkg::fbs_space_t sp, logic wr);
    logic ok;
    ok = 1'b0;
    unique case (ex)
      fbs_pkg::EXEC_BOOT: begin
        if (wr)
          ok = sp inside {fbs_pkg::SPC_USER, fbs_pkg::SPC_EEPROM,
                          fbs_pkg::SPC_HWBYTE, fbs_pkg::SPC_EXTRA_FLASH_ROW};
        else
          ok = sp inside {fbs_pkg::SPC_USER, fbs_pkg::SPC_BOOT,
                          fbs_pkg::SPC_EEPROM, fbs_pkg::SPC_HWBYTE};
      end
      fbs_pkg::EXEC_USER: begin
        if (wr)
          ok = sp inside {fbs_pkg::SPC_USER, fbs_pkg::SPC_EEPROM, fbs_pkg::SPC_EXTRA_FLASH_ROW};
        else
          ok = sp inside {fbs_pkg::SPC_USER, fbs_pkg::SPC_EEPROM, fbs_pkg::SPC_HWBYTE};
      end
      default: ok = (sp == fbs_pkg::SPC_EEPROM);
    endcase
    return ok;
  endfunction

  // Jump, vector, extra and status bytes are visible only to code running from boot flash
  always_comb begin
    svc_data = 8'h00;
    if (EXEC_SRC == fbs_pkg::EXEC_BOOT) begin
      unique case (st.svc_sel)
        fbs_pkg::SVC_JUMP:   svc_data = {7'h00, nv.jump};
        fbs_pkg::SVC_VECTOR: svc_data = nv.vector;
        fbs_pkg::SVC_EXTRA:  svc_data = nv.extra;
        fbs_pkg::SVC_STATUS: svc_data = nv.status;
      endcase
    end
  end

  always_comb begin
    reg_rd = 32'h0000_0000;
    unique case (HADDR[7:0])
      fbs_pkg::OFS_FLASH_CONTROL_REG: reg_rd[7:0] = st.flash_control_reg;
      fbs_pkg::OFS_AUX:  reg_rd[fbs_pkg::AUX_MAP_BIT] = st.map_en;
      fbs_pkg::OFS_STAT: begin
        reg_rd[15:0] = st.start_pc;
        reg_rd[fbs_pkg::STAT_HW_BIT] = st.hw_boot;
        reg_rd[fbs_pkg::STAT_JUMP_BIT] = st.jump_snap;
        reg_rd[fbs_pkg::STAT_PAGE_LSB +: 8] = st.last_page;
      end
      fbs_pkg::OFS_SVC: begin
        reg_rd[7:0] = svc_data;
        reg_rd[fbs_pkg::SVC_SEL_LSB +: 2] = st.svc_sel;
      end
      default: reg_rd = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_st = st;
    next_nv = nv;
    arr_we = 1'b0;
    arr_space = fbs_pkg::SPC_USER;
    arr_addr = 16'h0000;
    arr_data = 8'h00;
    if (!RESETN) begin
      // Straps and jump bit are caught on the first reset cycle only
      if (st.in_reset) begin
        next_st.in_reset = 1'b1;
      end else begin
        next_st.in_reset = 1'b1;
        next_st.hw_boot = !PROGRAM_STROBE_N && EXTERNAL_ACCESS_N
                          && ADDR_LATCH_STROBE;
        next_st.jump_snap = nv.jump;
      end
      next_st.map_en = next_st.jump_snap;
      if (next_st.hw_boot) begin
        next_st.flash_control_reg = fbs_pkg::FLASH_CONTROL_REG_HW_BOOT;
        next_st.start_pc = fbs_pkg::BOOT_START_PC;
      end else begin
        next_st.flash_control_reg = fbs_pkg::FLASH_CONTROL_REG_SW_BOOT;
        next_st.start_pc = next_st.jump_snap ? fbs_pkg::USER_START_PC
                                             : fbs_pkg::BOOT_START_PC;
      end
      next_st.wr_pend = 1'b0;
      next_st.wr_addr = 8'h00;
      next_st.hrdata = 32'h0000_0000;
      next_st.hreadyout = 1'b1;
      next_st.hresp = 1'b0;
      next_st.svc_sel = fbs_pkg::SVC_JUMP;
      next_st.last_page = 8'h00;
      next_st.code_ans = '0;
      next_st.mem_ans = '0;
      next_st.prg_ans = '0;
    end else begin
      next_st.in_reset = 1'b0;
      // Register write data phase
      if (st.wr_pend) begin
        if (st.wr_addr == fbs_pkg::OFS_FLASH_CONTROL_REG)
          next_st.flash_control_reg = HWDATA[7:0];
        if (st.wr_addr == fbs_pkg::OFS_AUX)
          next_st.map_en = HWDATA[fbs_pkg::AUX_MAP_BIT];
        if (st.wr_addr == fbs_pkg::OFS_SVC) begin
          next_st.svc_sel = fbs_pkg::fbs_svc_t'(HWDATA[fbs_pkg::SVC_SEL_LSB +: 2]);
          if (HWDATA[fbs_pkg::SVC_WE_BIT] && EXEC_SRC == fbs_pkg::EXEC_BOOT) begin
            unique case (next_st.svc_sel)
              fbs_pkg::SVC_JUMP:   next_nv.jump = HWDATA[0];
              fbs_pkg::SVC_VECTOR: next_nv.vector = HWDATA[7:0];
              fbs_pkg::SVC_EXTRA:  next_nv.extra = HWDATA[7:0];
              fbs_pkg::SVC_STATUS: next_nv.status = HWDATA[7:0];
            endcase
          end
        end
      end
      // Address phase: only whole-word writes are taken
      next_st.wr_pend = 1'b0;
      if (HSEL && HREADY && HTRANS[1]) begin
        next_st.wr_pend = HWRITE && (HSIZE == fbs_pkg::HSIZE_WORD);
        next_st.wr_addr = HADDR[7:0];
        if (!HWRITE)
          next_st.hrdata = reg_rd;
      end

      // Code-space reads steered by the space-select field
      next_st.code_ans = '0;
      if (CODE_REQ.req) begin
        next_st.code_ans.ack = 1'b1;
        if (EXEC_SRC == fbs_pkg::EXEC_EXT) begin
          next_st.code_ans.denied = 1'b1;
        end else begin
          unique case (fmod)
            fbs_pkg::FMOD_EXTRA_FLASH_ROW:   next_st.code_ans.data = extra_flash_row_peek;
            fbs_pkg::FMOD_HWBYTE: next_st.code_ans.data = nv.hw_byte;
            default: begin
              if (CODE_REQ.addr <= fbs_pkg::USER_TOP)
                next_st.code_ans.data = user_mem[CODE_REQ.addr[UA-1:0]];
              else if (CODE_REQ.addr >= fbs_pkg::BOOT_START_PC && st.map_en)
                next_st.code_ans.data = boot_mem[CODE_REQ.addr[BA-1:0]];
              else
                next_st.code_ans.denied = 1'b1;
            end
          endcase
        end
      end

      // Data accesses to flash spaces; the programming port wins the arrays
      next_st.mem_ans = '0;
      if (MEM_REQ.req) begin
        next_st.mem_ans.ack = 1'b1;
        if (!access_ok(EXEC_SRC, MEM_REQ.space, MEM_REQ.wr)
            || (MEM_REQ.wr && PRG_REQ.req
                && MEM_REQ.space inside {fbs_pkg::SPC_USER, fbs_pkg::SPC_EXTRA_FLASH_ROW})) begin
          next_st.mem_ans.denied = 1'b1;
        end else if (MEM_REQ.wr) begin
          if (MEM_REQ.space == fbs_pkg::SPC_HWBYTE)
            next_nv.hw_byte = MEM_REQ.wdata;
          else if (MEM_REQ.space != fbs_pkg::SPC_EEPROM) begin
            arr_we = 1'b1;
            arr_space = MEM_REQ.space;
            arr_addr = MEM_REQ.addr;
            arr_data = MEM_REQ.wdata;
          end
        end else begin
          unique case (MEM_REQ.space)
            fbs_pkg::SPC_USER:   next_st.mem_ans.data = user_mem[MEM_REQ.addr[UA-1:0]];
            fbs_pkg::SPC_BOOT:   next_st.mem_ans.data = boot_mem[MEM_REQ.addr[BA-1:0]];
            fbs_pkg::SPC_HWBYTE: next_st.mem_ans.data = nv.hw_byte;
            default:             next_st.mem_ans.data = 8'h00;
          endcase
        end
      end

      // Programming port: parallel reaches both arrays, serial only user flash
      next_st.prg_ans = '0;
      if (PRG_REQ.req) begin
        next_st.prg_ans.ack = 1'b1;
        if (PRG_REQ.boot && PRG_REQ.serial) begin
          next_st.prg_ans.denied = 1'b1;
        end else begin
          arr_we = 1'b1;
          arr_space = PRG_REQ.boot ? fbs_pkg::SPC_BOOT : fbs_pkg::SPC_USER;
          arr_addr = PRG_REQ.addr;
          arr_data = PRG_REQ.data;
          if (!PRG_REQ.boot)
            next_st.last_page = 8'(PRG_REQ.addr >> fbs_pkg::PAGE_SHIFT);
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    st <= next_st;
  end

  // Nonvolatile bytes survive reset
  always_ff @(posedge CLK) begin
    nv <= next_nv;
  end

  always_ff @(posedge CLK) begin
    if (arr_we) begin
      unique case (arr_space)
        fbs_pkg::SPC_BOOT: boot_mem[arr_addr[BA-1:0]] <= arr_data;
        fbs_pkg::SPC_EXTRA_FLASH_ROW: extra_flash_row_mem[arr_addr[fbs_pkg::EXTRA_FLASH_ROW_BITS-1:0]] <= arr_data;
        default:           user_mem[arr_addr[UA-1:0]] <= arr_data;
      endcase
    end
  end

  assign HREADYOUT = st.hreadyout;
  assign HRESP = st.hresp;
  assign HRDATA = st.hrdata;
  assign CODE_ANS = st.code_ans;
  assign MEM_ANS = st.mem_ans;
  assign PRG_ANS = st.prg_ans;
  assign START_PC = st.start_pc;
  assign BOOT_MAP_ENABLE = st.map_en;
  assign HW_BOOT = st.hw_boot;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_release;
    $rose(RESETN);
  endsequence

  sequence s_extra_flash_row_rd;
    CODE_REQ.req && fmod == fbs_pkg::FMOD_EXTRA_FLASH_ROW && EXEC_SRC != fbs_pkg::EXEC_EXT;
  endsequence

  property p_hw_boot;
    s_release ##0 HW_BOOT |-> START_PC == fbs_pkg::BOOT_START_PC && st.flash_control_reg == fbs_pkg::FLASH_CONTROL_REG_HW_BOOT;
  endproperty
  a_hw_boot: assert property (p_hw_boot) else $error("hardware boot start wrong");

  property p_sw_flash_control_reg;
    s_release ##0 !HW_BOOT |-> st.flash_control_reg == fbs_pkg::FLASH_CONTROL_REG_SW_BOOT;
  endproperty
  a_sw_flash_control_reg: assert property (p_sw_flash_control_reg) else $error("control value wrong");

  property p_user_start;
    s_release ##0 (!HW_BOOT && st.jump_snap) |-> START_PC == fbs_pkg::USER_START_PC;
  endproperty
  a_user_start: assert property (p_user_start) else $error("user start wrong");

  property p_boot_start;
    s_release ##0 (!HW_BOOT && !st.jump_snap) |-> START_PC == fbs_pkg::BOOT_START_PC;
  endproperty
  a_boot_start: assert property (p_boot_start) else $error("boot start wrong");

  property p_map_load;
    s_release |-> BOOT_MAP_ENABLE == nv.jump;
  endproperty
  a_map_load: assert property (p_map_load) else $error("map enable not loaded");

  property p_strap_hold;
    disable iff (1'b0) RESETN || !$past(RESETN) |=> $stable(HW_BOOT);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap result moved");

  property p_extra_flash_row_alias;
    s_extra_flash_row_rd |=> CODE_ANS.ack && !CODE_ANS.denied && CODE_ANS.data == $past(extra_flash_row_peek);
  endproperty
  a_extra_flash_row_alias: assert property (p_extra_flash_row_alias) else $error("extra row read wrong");

  property p_ext_deny;
    MEM_REQ.req && EXEC_SRC == fbs_pkg::EXEC_EXT && MEM_REQ.space != fbs_pkg::SPC_EEPROM
      |=> MEM_ANS.ack && MEM_ANS.denied;
  endproperty
  a_ext_deny: assert property (p_ext_deny) else $error("external code reached flash");

  property p_unmapped;
    CODE_REQ.req && EXEC_SRC != fbs_pkg::EXEC_EXT && fmod == fbs_pkg::FMOD_MAIN
      && CODE_REQ.addr >= fbs_pkg::BOOT_START_PC && !st.map_en |=> CODE_ANS.denied;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("boot flash leaked");

  property p_isp_boot;
    PRG_REQ.req && PRG_REQ.serial && PRG_REQ.boot |=> PRG_ANS.ack && PRG_ANS.denied;
  endproperty
  a_isp_boot: assert property (p_isp_boot) else $error("serial boot write taken");

  property p_svc_lock;
    st.wr_pend && st.wr_addr == fbs_pkg::OFS_SVC && EXEC_SRC != fbs_pkg::EXEC_BOOT
      |=> $stable(nv.jump) && $stable(nv.vector);
  endproperty
  a_svc_lock: assert property (p_svc_lock) else $error("protected byte changed");

  property p_boot_rd;
    MEM_REQ.req && !MEM_REQ.wr && EXEC_SRC == fbs_pkg::EXEC_BOOT
      && MEM_REQ.space == fbs_pkg::SPC_BOOT |=> MEM_ANS.ack && !MEM_ANS.denied;
  endproperty
  a_boot_rd: assert property (p_boot_rd) else $error("boot read refused");
endmodule

//--- testbench/fbs_strap_model.sv
// Strap pin drivers that sit outside the device around reset
`timescale 1ns/1ps
module fbs_strap_model (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic hw_mode,
  output logic      program_strobe_n,
  output logic      external_access_n,
  output logic      addr_latch_strobe
);
  logic released;

  initial released = 1'b1;

  // Released after the first sampling edge of reset, back under control once reset ends
  always @(posedge clk) begin
    released <= !resetn;
  end

  // Strobe starts high at power-on; a released strobe floats to its idle high level
  assign program_strobe_n  = released ? 1'b1 : !hw_mode;
  assign external_access_n = 1'b1;
  assign addr_latch_strobe = 1'b1;
endmodule

//--- testbench/flash_boot_select_tb.sv
// Self-checking testbench of the flash boot selection block
`timescale 1ns/1ps
module flash_boot_select_tb;
  logic                   clk;
  logic                   resetn;
  logic                   hw_mode;
  logic                   hsel;
  logic [31:0]            haddr;
  logic [1:0]             htrans;
  logic                   hwrite;
  logic [2:0]             hsize;
  logic [31:0]            hwdata;
  logic                   hreadyout;
  logic                   hresp;
  logic [31:0]            hrdata;
  logic                   strobe_n;
  logic                   ext_n;
  logic                   ale;
  fbs_pkg::fbs_exec_t     exec;
  fbs_pkg::fbs_code_req_t code_req;
  fbs_pkg::fbs_ans_t      code_ans;
  fbs_pkg::fbs_mem_req_t  mem_req;
  fbs_pkg::fbs_ans_t      mem_ans;
  fbs_pkg::fbs_prg_req_t  prg_req;
  fbs_pkg::fbs_ans_t      prg_ans;
  logic [15:0]            start_pc;
  logic                   map_en;
  logic                   hw_boot;
  logic [9:0]             exp_q[$];
  logic [9:0]             note;
  logic [31:0]            rnd;
  logic [31:0]            r;
  logic [7:0]             d;
  logic [15:0]            a;
  int                     error_cnt;
  int                     checks;
  logic [4:0]             ok [6] = '{5'b01101, 5'b10101, 5'b01111, 5'b11101, 5'b00100, 5'b00100};

  fbs_flash_boot_select u_dut (
    .CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
    .HRDATA(hrdata), .PROGRAM_STROBE_N(strobe_n), .EXTERNAL_ACCESS_N(ext_n), .ADDR_LATCH_STROBE(ale),
    .EXEC_SRC(exec), .CODE_REQ(code_req), .CODE_ANS(code_ans), .MEM_REQ(mem_req), .MEM_ANS(mem_ans),
    .PRG_REQ(prg_req), .PRG_ANS(prg_ans), .START_PC(start_pc), .BOOT_MAP_ENABLE(map_en), .HW_BOOT(hw_boot)
  );

  fbs_strap_model u_straps (
    .clk(clk), .resetn(resetn), .hw_mode(hw_mode), .program_strobe_n(strobe_n),
    .external_access_n(ext_n), .addr_latch_strobe(ale)
  );

  always #12.5 clk = !clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0000_00, adr};
    hwrite <= wr;
    hsize  <= fbs_pkg::HSIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({hreadyout, hresp}, 2'b10);
  endtask

  // Each request is held for one edge, then dropped for one edge before the next
  task automatic code(input logic [15:0] adr, input logic den, input logic cmp, input logic [7:0] dat);
    code_req <= '{1'b1, adr};
    exp_q.push_back({cmp, den, dat});
    @(posedge clk);
    code_req.req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic mem(input logic wr, input fbs_pkg::fbs_space_t sp, input logic [15:0] adr,
                     input logic [7:0] wd, input logic den, input logic cmp);
    mem_req <= '{1'b1, wr, sp, adr, wd};
    exp_q.push_back({cmp, den, 8'h00});
    @(posedge clk);
    mem_req.req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic prg(input logic ser, input logic bt, input logic [15:0] adr, input logic [7:0] dat,
                     input logic den);
    prg_req <= '{1'b1, ser, bt, adr, dat};
    exp_q.push_back({1'b1, den, 8'h00});
    @(posedge clk);
    prg_req.req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rst(input logic hw, input logic jmp, input int n);
    hw_mode <= hw;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (n) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(start_pc, (hw || !jmp) ? fbs_pkg::BOOT_START_PC : fbs_pkg::USER_START_PC);
    chk(map_en, jmp);
    chk(hw_boot, hw);
    ahb(1'b0, fbs_pkg::OFS_FLASH_CONTROL_REG, 32'h0000_0000, r);
    chk(r[7:0], hw ? fbs_pkg::FLASH_CONTROL_REG_HW_BOOT : fbs_pkg::FLASH_CONTROL_REG_SW_BOOT);
    ahb(1'b0, fbs_pkg::OFS_STAT, 32'h0000_0000, r);
    chk(r[17:16], {jmp, hw});
  endtask

  task automatic svc_rd(input logic [1:0] sel, output logic [31:0] rd);
    ahb(1'b1, fbs_pkg::OFS_SVC, {22'h0, sel, 8'h00}, rd);
    ahb(1'b0, fbs_pkg::OFS_SVC, 32'h0000_0000, rd);
  endtask

  // Answers are single-cycle pulses; each is matched to the oldest pending note
  always @(negedge clk) begin
    if (resetn && (code_ans.ack === 1'b1 || mem_ans.ack === 1'b1 || prg_ans.ack === 1'b1)) begin
      if (exp_q.size() == 0) begin
        chk(32'h0000_0001, 32'h0000_0000);
      end else begin
        note = exp_q.pop_front();
        chk(code_ans.ack ? code_ans.denied : mem_ans.ack ? mem_ans.denied : prg_ans.denied, note[8]);
        if (note[9]) chk(code_ans.ack ? code_ans.data : mem_ans.ack ? mem_ans.data : prg_ans.data, note[7:0]);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    clk = 1'b0; resetn = 1'b0; hw_mode = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = fbs_pkg::HSIZE_WORD; hwdata = '0; exec = fbs_pkg::EXEC_BOOT; code_req = '0; mem_req = '0;
    prg_req = '0; rnd = 32'h5e63; error_cnt = 0; checks = 0;
    rst(1'b0, 1'b0, 6);
    svc_rd(2'd0, r);
    chk(r[7:0], 8'h00);
    svc_rd(2'd1, r);
    chk(r[7:0], 8'hFC);
    exec <= fbs_pkg::EXEC_USER;
    svc_rd(2'd1, r);
    chk(r[7:0], 8'h00);
    ahb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    @(posedge clk);
    for (int e = 0; e < 3; e++) begin
      for (int s = 0; s < 5; s++) begin
        for (int w = 0; w < 2; w++) begin
          exec <= fbs_pkg::fbs_exec_t'(e[1:0]);
          mem(w[0], fbs_pkg::fbs_space_t'(s[2:0]), (s == 1) ? 16'hF820 : 16'h0020, 8'hFF,
              !ok[e * 2 + w][s], w == 0 && s == 2);
        end
      end
    end
    exec <= fbs_pkg::EXEC_BOOT;
    rnd = lfsr(rnd);
    a = {1'b0, rnd[14:0]};
    d = rnd[23:16];
    prg(1'b1, 1'b1, 16'hF810, d, 1'b1);
    prg(1'b1, 1'b0, a, d, 1'b0);
    prg(1'b0, 1'b1, 16'hF810, ~d, 1'b0);
    ahb(1'b0, fbs_pkg::OFS_STAT, 32'h0000_0000, r);
    chk(r[31:24], a[14:7]);
    ahb(1'b1, fbs_pkg::OFS_FLASH_CONTROL_REG, 32'h0000_0000, r);
    @(posedge clk);
    code(a, 1'b0, 1'b1, d);
    code(16'h8000, 1'b1, 1'b0, 8'h00);
    code(16'hF810, 1'b1, 1'b0, 8'h00);
    ahb(1'b1, fbs_pkg::OFS_AUX, 32'h0000_0020, r);
    @(negedge clk);
    chk(map_en, 1'b1);
    @(posedge clk);
    code(16'hF810, 1'b0, 1'b1, ~d);
    ahb(1'b1, fbs_pkg::OFS_AUX, 32'h0000_0000, r);
    rnd = lfsr(rnd);
    @(posedge clk);
    mem(1'b1, fbs_pkg::SPC_EXTRA_FLASH_ROW, 16'h0005, rnd[7:0], 1'b0, 1'b0);
    mem(1'b1, fbs_pkg::SPC_HWBYTE, 16'h0000, rnd[15:8], 1'b0, 1'b0);
    ahb(1'b1, fbs_pkg::OFS_FLASH_CONTROL_REG, 32'h0000_0002, r);
    @(posedge clk);
    code(16'h0085, 1'b0, 1'b1, rnd[7:0]);
    code(16'hFF05, 1'b0, 1'b1, rnd[7:0]);
    ahb(1'b1, fbs_pkg::OFS_FLASH_CONTROL_REG, 32'h0000_0004, r);
    @(posedge clk);
    code(16'h1234, 1'b0, 1'b1, rnd[15:8]);
    ahb(1'b1, fbs_pkg::OFS_FLASH_CONTROL_REG, 32'h0000_0006, r);
    @(posedge clk);
    code(a, 1'b0, 1'b1, d);
    exec <= fbs_pkg::EXEC_EXT;
    code(16'h0010, 1'b1, 1'b0, 8'h00);
    exec <= fbs_pkg::EXEC_BOOT;
    ahb(1'b1, fbs_pkg::OFS_SVC, 32'h0000_0401, r);
    rst(1'b0, 1'b1, 2);
    rst(1'b1, 1'b1, 2);
    repeat (3) @(posedge clk);
    chk(exp_q.size(), 0);
    results();
  end
endmodule
